// File: hdl/clock_gen_ctrl_regs.sv
// What this block does
// - Byte 3 bit 7: stopped reference outputs driven at 0, tri-stated at 1; resets 1.
// - Byte 3 bit 6: processor pairs tri-state in power-down when 1; resets 0.
// - Byte 3 bit 5: reference pairs tri-state in power-down when 1; resets 1.
// - Byte 3 bit 0: link-rate clock drive, 0 high, 1 low; resets 1.
// - Byte 4 bits 7..2 make outputs 5..0 stoppable by request 0; reset 0.
// - Byte 5 bits 7..2 make outputs 5..0 stoppable by request 1; reset 0.
// - Byte 4 bit 1 enables the link-rate clock output; resets 1.
// - Byte 6 bit 6 enters test clock mode; resets 0.
// - Byte 6 bit 7 picks divided reference (1) or tri-state (0); resets 0.
// - Byte 6 bit 5 reference drive, 0 low, 1 high; resets 0.
// - Request levels accepted only after two equal complement-clock rising edges.
// - Stop at next true-leg rise (complement fall); mode 0 true high comp low, mode 1 undriven.
// - Each stopped output resumes, glitch free, within 2 to 6 periods once all requests selecting it are low.
`timescale 1ns/100ps
module clock_gen_ctrl_regs
	import clock_gen_ctrl_pkg::*;
#(
	// Arbitrary identification values
	parameter logic [3:0] REVISION_CODE = 4'h3,
	parameter logic [3:0] VENDOR_CODE   = 4'h5
) (
	// Clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   rst_n,
	// Indexed byte access from the serial engine
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	input  wire logic [OFS_W-1:0]       reg_offset,
	input  wire logic [7:0]             reg_wdata,
	output logic      [7:0]             reg_rdata,
	// Clock request pins and complement clock
	input  wire logic                   clock_request_n_0,
	input  wire logic                   clock_request_n_1,
	input  wire logic                   differential_complement_clock,
	// Serial reference differential outputs
	output logic      [NUM_SRC-1:0]     serial_reference_true_leg,
	output logic      [NUM_SRC-1:0]     serial_reference_comp_leg,
	output logic      [NUM_SRC-1:0]     serial_reference_diff_out_oe,
	// Static controls toward the output buffers
	output logic                        link_rate_clock_out_en,
	output logic                        link_rate_clock_out_low_drive,
	output logic                        cpu_pd_tristate,
	output logic                        src_pd_tristate,
	output logic                        test_mode_en,
	output logic                        test_ref_div_sel,
	output logic                        ref_high_drive
);

	////////////////////////////////////////////////////////////////////////////////
	logic [1:0]            rst_pipe_reg;
	logic                  rst_sync_n;
	logic [7:0]            drive_mode_reg;
	logic [7:0]            req0_sel_reg;
	logic [7:0]            req1_sel_reg;
	logic [7:0]            test_ref_reg;
	logic                  differential_complement_clock_q_reg;
	logic                  differential_complement_clock_rise;
	logic                  differential_complement_clock_fall;
	logic [NUM_REQ-1:0]    req_pin;
	logic [NUM_REQ-1:0]    req_samp_reg;
	logic [NUM_REQ-1:0]    req_high_reg;
	logic [NUM_SRC-1:0]    stop_req;
	logic [NUM_SRC-1:0]    stopped_reg;
	logic [NUM_SRC-1:0]    stopped_next;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			rst_pipe_reg <= 2'h0;
		else
			rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
	end
	assign rst_sync_n = rst_pipe_reg[1];

	////////////////////////////////////////////////////////////////////////////////
	// Control bytes; reserved bits are not stored
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			drive_mode_reg <= RST_DRIVE_MODE;
			req0_sel_reg   <= RST_REQ0_SEL;
			req1_sel_reg   <= RST_REQ1_SEL;
			test_ref_reg   <= RST_TEST_REF;
		end else if (reg_wr) begin
			case (reg_offset)
				OFS_DRIVE_MODE: drive_mode_reg <= (reg_wdata & ~RSVD_MASK_B3)
					| (RST_DRIVE_MODE & RSVD_MASK_B3);
				OFS_REQ0_SEL:   req0_sel_reg <= (reg_wdata & ~RSVD_MASK_B4)
					| (RST_REQ0_SEL & RSVD_MASK_B4);
				OFS_REQ1_SEL:   req1_sel_reg <= (reg_wdata & ~RSVD_MASK_B5)
					| (RST_REQ1_SEL & RSVD_MASK_B5);
				OFS_TEST_REF:   test_ref_reg <= (reg_wdata & ~RSVD_MASK_B6)
					| (RST_TEST_REF & RSVD_MASK_B6);
				default: ;  // Ident byte and unmapped offsets ignore writes
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			reg_rdata <= RD_UNMAPPED;
		else if (reg_rd) begin
			case (reg_offset)
				OFS_DRIVE_MODE: reg_rdata <= drive_mode_reg;
				OFS_REQ0_SEL:   reg_rdata <= req0_sel_reg;
				OFS_REQ1_SEL:   reg_rdata <= req1_sel_reg;
				OFS_TEST_REF:   reg_rdata <= test_ref_reg;
				OFS_IDENT:      reg_rdata <= {REVISION_CODE, VENDOR_CODE};
				default:        reg_rdata <= RD_UNMAPPED;
			endcase
		end
	end

	assign link_rate_clock_out_low_drive = drive_mode_reg[B3_LINK_LOW_DRV];
	assign cpu_pd_tristate               = drive_mode_reg[B3_CPU_PD_TRI];
	assign src_pd_tristate               = drive_mode_reg[B3_SRC_PD_TRI];
	assign link_rate_clock_out_en        = req0_sel_reg[B4_LINK_EN];
	assign test_mode_en                  = test_ref_reg[B6_TEST_MODE];
	assign test_ref_div_sel              = test_ref_reg[B6_TEST_SEL];
	assign ref_high_drive                = test_ref_reg[B6_REF_HIGH_DRV];

	////////////////////////////////////////////////////////////////////////////////
	// Request debounce on complement-clock rising edges
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			differential_complement_clock_q_reg <= 1'b0;
		else
			differential_complement_clock_q_reg <= differential_complement_clock;
	end
	assign differential_complement_clock_rise = differential_complement_clock & ~differential_complement_clock_q_reg;
	assign differential_complement_clock_fall = ~differential_complement_clock & differential_complement_clock_q_reg;
	assign req_pin   = {clock_request_n_1, clock_request_n_0};

	// Reset as asserted (low): nothing stops until the host releases a request
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			req_samp_reg <= '0;
			req_high_reg <= '0;
		end else if (differential_complement_clock_rise) begin
			req_samp_reg <= req_pin;
			for (int r = 0; r < NUM_REQ; r++) begin
				if (req_pin[r] == req_samp_reg[r])
					req_high_reg[r] <= req_pin[r];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stop and resume; the true leg is the inverse of the complement clock
	assign stop_req = (req0_sel_reg[SEL_MSB:SEL_LSB] & {NUM_SRC{req_high_reg[0]}})
		| (req1_sel_reg[SEL_MSB:SEL_LSB] & {NUM_SRC{req_high_reg[1]}});

	// Freeze on the true leg's rise, release on its fall: no runt pulse either way
	always_comb begin
		stopped_next = stopped_reg;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (stop_req[i] && differential_complement_clock_fall)
				stopped_next[i] = 1'b1;
			else if (!stop_req[i] && differential_complement_clock_rise)
				stopped_next[i] = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			stopped_reg                  <= '0;
			serial_reference_true_leg    <= '0;
			serial_reference_comp_leg    <= '0;
			serial_reference_diff_out_oe <= '0;
		end else begin
			stopped_reg <= stopped_next;
			for (int i = 0; i < NUM_SRC; i++) begin
				if (stopped_next[i] && drive_mode_reg[B3_STOP_TRI]) begin
					serial_reference_true_leg[i]    <= 1'b0;
					serial_reference_comp_leg[i]    <= 1'b0;
					serial_reference_diff_out_oe[i] <= 1'b0;
				end else if (stopped_next[i]) begin
					serial_reference_true_leg[i]    <= 1'b1;
					serial_reference_comp_leg[i]    <= 1'b0;
					serial_reference_diff_out_oe[i] <= 1'b1;
				end else begin
					serial_reference_true_leg[i]    <= ~differential_complement_clock;
					serial_reference_comp_leg[i]    <= differential_complement_clock;
					serial_reference_diff_out_oe[i] <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	// Legs were loaded with the mode bit of the previous edge; a mode write lands one cycle later
	property p_stop_mode0;
		@(posedge ref_clk) disable iff (!rst_sync_n)
		stopped_reg[0] && !$past(drive_mode_reg[B3_STOP_TRI]) |-> serial_reference_true_leg[0]
			&& !serial_reference_comp_leg[0] && serial_reference_diff_out_oe[0];
	endproperty
	a_stop_mode0: assert property (p_stop_mode0) else $error("stopped leg not held");

	property p_stop_mode1;
		@(posedge ref_clk) disable iff (!rst_sync_n)
		stopped_reg[0] && $past(drive_mode_reg[B3_STOP_TRI]) |-> !serial_reference_diff_out_oe[0];
	endproperty
	a_stop_mode1: assert property (p_stop_mode1) else $error("stopped leg driven");

	property p_drive_wr;
		@(posedge ref_clk) disable iff (!rst_sync_n)
		reg_wr && reg_offset == OFS_DRIVE_MODE |=> cpu_pd_tristate == $past(reg_wdata[6])
			&& src_pd_tristate == $past(reg_wdata[5])
			&& link_rate_clock_out_low_drive == $past(reg_wdata[0]);
	endproperty
	a_drive_wr: assert property (p_drive_wr) else $error("byte 3 write lost");

	property p_pd_src;
		@(posedge ref_clk) disable iff (!rst_sync_n)
		reg_wr && reg_offset == OFS_DRIVE_MODE && reg_wdata[5] |=> src_pd_tristate;
	endproperty
	a_pd_src: assert property (p_pd_src) else $error("src pd mode wrong");

	property p_link_en;
		@(posedge ref_clk) disable iff (!rst_sync_n)
		reg_wr && reg_offset == OFS_REQ0_SEL |=> link_rate_clock_out_en == $past(reg_wdata[1]);
	endproperty
	a_link_en: assert property (p_link_en) else $error("link enable wrong");

	property p_test_wr;
		@(posedge ref_clk) disable iff (!rst_sync_n)
		reg_wr && reg_offset == OFS_TEST_REF |=> test_mode_en == $past(reg_wdata[6])
			&& test_ref_div_sel == $past(reg_wdata[7]) && ref_high_drive == $past(reg_wdata[5]);
	endproperty
	a_test_wr: assert property (p_test_wr) else $error("byte 6 write lost");

	property p_ident;
		@(posedge ref_clk) disable iff (!rst_sync_n)
		reg_rd && reg_offset == OFS_IDENT |=> reg_rdata == {REVISION_CODE, VENDOR_CODE};
	endproperty
	a_ident: assert property (p_ident) else $error("ident byte wrong");

	property p_debounce;
		@(posedge ref_clk) disable iff (!rst_sync_n)
		$changed(req_high_reg[0]) |-> $past(differential_complement_clock_rise) && $past(req_samp_reg[0]) == req_high_reg[0];
	endproperty
	a_debounce: assert property (p_debounce) else $error("request taken early");

	property p_stop_edge;
		@(posedge ref_clk) disable iff (!rst_sync_n)
		$rose(stopped_reg[0]) |-> $past(differential_complement_clock_fall) && $past(stop_req[0]);
	endproperty
	a_stop_edge: assert property (p_stop_edge) else $error("stop off edge");

	property p_resume;
		@(posedge ref_clk) disable iff (!rst_sync_n)
		stopped_reg[0] && !stop_req[0] && differential_complement_clock_rise |=> !stopped_reg[0]
			&& !serial_reference_true_leg[0];
	endproperty
	a_resume: assert property (p_resume) else $error("no resume");

	c_stop:   cover property (@(posedge ref_clk) disable iff (!rst_sync_n) $rose(stopped_reg[0]));
	c_resume: cover property (@(posedge ref_clk) disable iff (!rst_sync_n) $fell(stopped_reg[0]));
	c_tri:    cover property (@(posedge ref_clk) disable iff (!rst_sync_n)
		stopped_reg[0] && !serial_reference_diff_out_oe[0]);

endmodule : clock_gen_ctrl_regs

// File: hdl/clock_gen_ctrl_pkg.sv
package clock_gen_ctrl_pkg;

	// Indexed byte offsets, as carried in the command code
	localparam int          OFS_W           = 5;
	localparam logic [4:0]  OFS_DRIVE_MODE  = 5'h03;
	localparam logic [4:0]  OFS_REQ0_SEL    = 5'h04;
	localparam logic [4:0]  OFS_REQ1_SEL    = 5'h05;
	localparam logic [4:0]  OFS_TEST_REF    = 5'h06;
	localparam logic [4:0]  OFS_IDENT       = 5'h07;

	// Field positions
	localparam int          B3_STOP_TRI     = 7;
	localparam int          B3_CPU_PD_TRI   = 6;
	localparam int          B3_SRC_PD_TRI   = 5;
	localparam int          B3_LINK_LOW_DRV = 0;
	localparam int          B4_LINK_EN      = 1;
	localparam int          SEL_LSB         = 2;
	localparam int          SEL_MSB         = 7;
	localparam int          B6_TEST_SEL     = 7;
	localparam int          B6_TEST_MODE    = 6;
	localparam int          B6_REF_HIGH_DRV = 5;
	localparam int          NUM_SRC         = 6;
	localparam int          NUM_REQ         = 2;

	// Power-up values; reserved bits read back as these
	localparam logic [7:0]  RST_DRIVE_MODE  = 8'haf;
	localparam logic [7:0]  RST_REQ0_SEL    = 8'h03;
	localparam logic [7:0]  RST_REQ1_SEL    = 8'h00;
	localparam logic [7:0]  RST_TEST_REF    = 8'h10;
	localparam logic [7:0]  RSVD_MASK_B3    = 8'h1e;
	localparam logic [7:0]  RSVD_MASK_B4    = 8'h01;
	localparam logic [7:0]  RSVD_MASK_B5    = 8'h03;
	localparam logic [7:0]  RSVD_MASK_B6    = 8'h1f;
	localparam logic [7:0]  RD_UNMAPPED     = 8'h00;

endpackage : clock_gen_ctrl_pkg

// File: verification/clock_request_host.sv
`timescale 1ns/100ps
module clock_request_host (
	// Device clock
	input  wire logic ref_clk,
	// Stop wishes from the bench
	input  wire logic want_stop_0,
	input  wire logic want_stop_1,
	// Pins toward the device
	output logic      differential_complement_clock,
	output logic      clock_request_n_0,
	output logic      clock_request_n_1
);
	logic half_cnt;

	initial begin
		half_cnt = 1'b0;
		differential_complement_clock = 1'b0;
		clock_request_n_0 = 1'b0;
		clock_request_n_1 = 1'b0;
	end

	// Reference runs free, four device cycles a period
	always @(negedge ref_clk) begin
		half_cnt <= ~half_cnt;
		if (half_cnt) begin
			differential_complement_clock <= ~differential_complement_clock;
		end
	end

	// Pins move on falling edges only, so each level spans at least one rising edge
	always @(negedge differential_complement_clock) begin
		clock_request_n_0 <= want_stop_0;
		clock_request_n_1 <= want_stop_1;
	end
endmodule : clock_request_host

// File: verification/clock_gen_ctrl_regs_bench.sv
`timescale 1ns/100ps
module clock_gen_ctrl_regs_bench;
	import clock_gen_ctrl_pkg::*;
	localparam logic [3:0] REV = 4'h3; // Arbitrary
	localparam logic [3:0] VEN = 4'h5; // Arbitrary
	logic               ref_clk, rst_n, reg_wr, reg_rd, want_stop_0, want_stop_1;
	logic               dcc, req_n_0, req_n_1, first;
	logic [OFS_W-1:0]   reg_offset;
	logic [7:0]         reg_wdata, reg_rdata;
	logic [NUM_SRC-1:0] true_leg, comp_leg, leg_oe;
	logic               link_en, link_low, cpu_pd, src_pd, tst_en, tst_sel, ref_hi;
	logic [7:0]         wd [3:6];
	int                 failures, checks_done, n;

	clock_gen_ctrl_regs #(.REVISION_CODE(REV), .VENDOR_CODE(VEN)) dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_offset(reg_offset), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.clock_request_n_0(req_n_0), .clock_request_n_1(req_n_1),
		.differential_complement_clock(dcc), .serial_reference_true_leg(true_leg),
		.serial_reference_comp_leg(comp_leg), .serial_reference_diff_out_oe(leg_oe),
		.link_rate_clock_out_en(link_en), .link_rate_clock_out_low_drive(link_low),
		.cpu_pd_tristate(cpu_pd), .src_pd_tristate(src_pd), .test_mode_en(tst_en),
		.test_ref_div_sel(tst_sel), .ref_high_drive(ref_hi));
	clock_request_host host (.ref_clk(ref_clk), .want_stop_0(want_stop_0),
		.want_stop_1(want_stop_1), .differential_complement_clock(dcc),
		.clock_request_n_0(req_n_0), .clock_request_n_1(req_n_1));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task print_verdict;
		$display("failures=%0d checks_done=%0d", failures, checks_done);
		if (failures == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict

	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task step(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask : step

	task wr(input logic [4:0] o, input logic [7:0] d);
		reg_wr = 1'b1;
		reg_offset = o;
		reg_wdata = d;
		step(1);
		reg_wr = 1'b0;
		step(1);
	endtask : wr

	task rd(input logic [4:0] o, input logic [7:0] exp);
		reg_rd = 1'b1;
		reg_offset = o;
		step(1);
		reg_rd = 1'b0;
		step(1);
		chk(reg_rdata, exp);
	endtask : rd

	// Reserved bits keep power-up values
	function automatic logic [7:0] merge(input logic [7:0] d, input int i);
		logic [7:0] m;
		logic [7:0] r;
		m = (i == 3) ? RSVD_MASK_B3 : (i == 4) ? RSVD_MASK_B4 : (i == 5) ? RSVD_MASK_B5 : RSVD_MASK_B6;
		r = (i == 3) ? 8'h0e : (i == 4) ? 8'h01 : (i == 5) ? 8'h00 : 8'h10;
		return (d & ~m) | (r & m);
	endfunction : merge

	task toggles(input int i);
		first = comp_leg[i];
		n = 0;
		repeat (8) begin
			step(1);
			if (comp_leg[i] !== first) n = 1;
		end
		chk(8'(n), 8'h01);
	endtask : toggles

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		failures = 0;
		checks_done = 0;
		{rst_n, reg_wr, reg_rd, want_stop_0, want_stop_1} = 5'h00;
		reg_offset = 5'h00;
		reg_wdata = 8'h00;
		wd[3] = 8'h40;
		wd[4] = 8'hfc;
		wd[5] = 8'h5c;
		wd[6] = 8'he0;
		step(8);
		rst_n = 1'b1;
		step(4);
		rd(OFS_DRIVE_MODE, 8'haf);
		rd(OFS_REQ0_SEL, 8'h03);
		rd(OFS_REQ1_SEL, 8'h00);
		rd(OFS_TEST_REF, 8'h10);
		chk({1'b0, link_en, link_low, cpu_pd, src_pd, tst_en, tst_sel, ref_hi}, 8'h68);
		for (int i = 3; i <= 6; i++) begin
			wr(5'(i), wd[i]);
			rd(5'(i), merge(wd[i], i));
		end
		chk({1'b0, link_en, link_low, cpu_pd, src_pd, tst_en, tst_sel, ref_hi}, 8'h17);
		wr(OFS_IDENT, 8'hff);
		rd(OFS_IDENT, {REV, VEN});
		wr(5'h08, 8'hff);
		rd(5'h08, 8'h00);
		wr(OFS_TEST_REF, 8'h00);
		// Outputs 0 and 5 on request 0, output 5 also on request 1
		wr(OFS_REQ0_SEL, 8'h84);
		wr(OFS_REQ1_SEL, 8'h80);
		// Pin high for one period spans a single complement rise: must be ignored
		want_stop_0 = 1'b1;
		n = 0;
		while (req_n_0 !== 1'b1 && n < 8) begin
			step(1);
			n++;
		end
		want_stop_0 = 1'b0;
		chk({7'b0, req_n_0}, 8'h01);
		repeat (16) begin
			step(1);
			chk({7'b0, comp_leg[0]}, {7'b0, comp_leg[1]});
		end
		want_stop_0 = 1'b1;
		step(24);
		chk({2'b0, true_leg} & 8'h21, 8'h21);
		chk({2'b0, comp_leg} & 8'h21, 8'h00);
		chk({2'b0, leg_oe}, 8'h3f);
		toggles(1);
		want_stop_0 = 1'b0;
		want_stop_1 = 1'b1;
		step(24);
		chk({2'b0, true_leg} & 8'h20, 8'h20);
		toggles(0);
		wr(OFS_DRIVE_MODE, 8'h80);
		want_stop_0 = 1'b1;
		step(24);
		chk({2'b0, leg_oe}, 8'h1e);
		want_stop_0 = 1'b0;
		want_stop_1 = 1'b0;
		// Bound: one period for the host to move the pin, then six reference periods
		n = 0;
		while (leg_oe !== 6'h3f && n < 28) begin
			chk({7'b0, leg_oe[0]}, {7'b0, leg_oe[5]});
			step(1);
			n++;
		end
		chk({2'b0, leg_oe}, 8'h3f);
		toggles(5);
		print_verdict();
	end
endmodule : clock_gen_ctrl_regs_bench
